// *** hdl/logic_cell_top.sv ***
/*
 * Logic cell: four-input lookup table, programmable register, three routing
 * outputs, carry and register chains, configured over Avalon-MM.
 * Assumes routing data, carry and chain inputs are on clock_i; clock, clear,
 * enable and device clear pins are asynchronous and synchronised here.
 */
// Chosen here: the register addresses and register access over Avalon-MM.
// Contract
// - lookup table of four inputs realises any function of them
// - register acts as D, T, JK or SR flip-flop by configuration
// - register has data, clock, clock enable and clear inputs
// - clock and clear from global, pin or logic; enable from pin or logic
// - combinational result bypasses the register to the outputs
// - three outputs, each selects table or register independently
// - two outputs feed row/column and direct link, one feeds local
// - packing lets table and register drive different outputs for unrelated work
// - packing disables the cluster synchronous load for this register
// - feedback mode routes register output into the same table
// - registered and unregistered table result may show at once
// - register chain output feeds neighbour register for shift chains
// - one table input is carry-in or fourth input, by configuration
// - arithmetic mode gives full adder bit with carry out
// - synchronous clear and load are cluster-wide register controls
// - device-wide reset clears register, overriding every other control
`timescale 1ns/1ps
`include "logic_cell_regs.svh"

module logic_cell_top (
    input wire logic clock_i,
    input wire logic rst_n_i,
    // register bus
    input wire cell_pkg::avmm_req_t avmm_req_i,
    output cell_pkg::avmm_rsp_t avmm_rsp_o,
    // routing data and neighbours
    input wire logic [3:0] data_i,
    input wire logic carry_i,
    input wire logic chain_i,
    input wire logic sync_clear_i,
    input wire logic sync_load_i,
    // asynchronous control sources
    input wire logic clear_global_i,
    input wire logic clock_pin_i,
    input wire logic clear_pin_i,
    input wire logic enable_pin_i,
    input wire logic dev_clear_n_i,
    // outputs
    output cell_pkg::route_out_t route_o,
    output logic carry_o,
    output logic chain_o
);
    import cell_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // declarations

    localparam int PINS = `CELL_PIN_COUNT;

    logic [15:0] lut_mask_q;
    logic [`CELL_CFG_WIDTH-1:0] cfg_q;
    logic [`CELL_OUT_SEL_WIDTH-1:0] out_sel_q;
    logic sw_clk_q;
    logic sw_clr_q;
    logic sw_ce_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [PINS-1:0] sync1_q;
    logic [PINS-1:0] sync2_q;
    logic clk_pin_prev_q;
    logic bus_req;
    logic bus_take;
    logic wr_take;
    logic [31:0] wmask;

    ff_type_t ff_type;
    ctl_src_t clk_src;
    ctl_src_t clr_src;
    logic ce_from_logic;
    logic in3_carry;
    logic arith_mode;
    logic feedback_en;
    logic pack_en;
    logic chain_en;

    logic clear_global_s;
    logic clock_pin_s;
    logic clear_pin_s;
    logic enable_pin_s;
    logic dev_clear_s;

    logic reg_tick;
    logic reg_clr;
    logic reg_ce;
    logic reg_q;
    logic reg_d;
    logic sload_eff;
    logic lut_a;
    logic lut_b;
    logic lut_c;
    logic lut_d;
    logic lut_out;
    logic lut_result;
    logic sum_bit;
    logic carry_bit;
    route_out_t route;

    //////////////////////////////////////////////////////////////////////////
    // configuration fields
    assign ff_type = ff_type_t'(cfg_q[`CELL_CFG_FF_TYPE_LSB +: 2]);
    assign clk_src = ctl_src_t'(cfg_q[`CELL_CFG_CLK_SRC_LSB +: 2]);
    assign clr_src = ctl_src_t'(cfg_q[`CELL_CFG_CLR_SRC_LSB +: 2]);
    assign ce_from_logic = cfg_q[`CELL_CFG_CE_SRC_BIT];
    assign in3_carry = cfg_q[`CELL_CFG_IN3_CARRY_BIT];
    assign arith_mode = cfg_q[`CELL_CFG_ARITH_BIT];
    assign feedback_en = cfg_q[`CELL_CFG_FEEDBACK_BIT];
    assign pack_en = cfg_q[`CELL_CFG_PACK_BIT];
    assign chain_en = cfg_q[`CELL_CFG_CHAIN_BIT];

    //////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for the asynchronous control pins
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {~dev_clear_n_i, enable_pin_i, clear_pin_i, clock_pin_i,
                        clear_global_i};
            sync2_q <= sync1_q;
        end
    end

    assign clear_global_s = sync2_q[0];
    assign clock_pin_s = sync2_q[1];
    assign clear_pin_s = sync2_q[2];
    assign enable_pin_s = sync2_q[3];
    assign dev_clear_s = sync2_q[4];

    // previous synchronised pin clock, for its rising edge
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_pin_prev_q <= 1'b0;
        end else begin
            clk_pin_prev_q <= clock_pin_s;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // register clock, clear and enable source selection
    always_comb begin
        case (clk_src)
            SRC_GLOBAL: reg_tick = 1'b1;
            SRC_PIN: reg_tick = clock_pin_s & ~clk_pin_prev_q;
            SRC_LOGIC: reg_tick = sw_clk_q;
            default: reg_tick = 1'b0;
        endcase
    end

    always_comb begin
        case (clr_src)
            SRC_GLOBAL: reg_clr = clear_global_s;
            SRC_PIN: reg_clr = clear_pin_s;
            SRC_LOGIC: reg_clr = sw_clr_q;
            default: reg_clr = 1'b0;
        endcase
    end

    // enable has no global source
    assign reg_ce = ce_from_logic ? sw_ce_q : enable_pin_s;

    //////////////////////////////////////////////////////////////////////////
    // lookup table inputs and function
    assign lut_a = data_i[0];
    assign lut_b = data_i[1];
    assign lut_c = feedback_en ? reg_q : data_i[2];
    assign lut_d = in3_carry ? carry_i : data_i[3];

    // sixteen-entry mask indexed by the four inputs
    assign lut_out = lut_mask_q[{lut_d, lut_c, lut_b, lut_a}];

    // adder bit from the two operands and incoming carry
    assign sum_bit = lut_a ^ lut_b ^ carry_i;
    assign carry_bit = (lut_a & lut_b) | (carry_i & (lut_a ^ lut_b));
    assign lut_result = arith_mode ? sum_bit : lut_out;
    assign carry_o = arith_mode & carry_bit;

    //////////////////////////////////////////////////////////////////////////
    // register data path
    always_comb begin
        if (chain_en) begin
            reg_d = chain_i;
        end else if (pack_en) begin
            reg_d = data_i[3];
        end else begin
            reg_d = lut_result;
        end
    end

    // packing and synchronous load exclude each other
    assign sload_eff = sync_load_i & ~pack_en;

    cell_storage u_storage (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .tick_i(reg_tick),
        .ce_i(reg_ce),
        .clr_i(reg_clr),
        .dev_clr_i(dev_clear_s),
        .sclr_i(sync_clear_i),
        .sload_i(sload_eff),
        .sload_data_i(data_i[2]),
        .d_i(reg_d),
        .aux_i(data_i[1]),
        .ff_type_i(ff_type),
        .q_o(reg_q)
    );

    // register chain to the neighbour cell
    assign chain_o = reg_q;

    //////////////////////////////////////////////////////////////////////////
    // routing outputs, each picks table or register
    always_comb begin
        route.row_col = out_sel_q[0] ? reg_q : lut_result;
        route.direct_link = out_sel_q[1] ? reg_q : lut_result;
        route.local_out = out_sel_q[2] ? reg_q : lut_result;
    end

    // combinational result bypasses the register; mixed selects show both
    assign route_o = route;

    //////////////////////////////////////////////////////////////////////////
    // avalon-mm handshake: one wait cycle, answer on the second edge
    assign bus_req = avmm_req_i.read | avmm_req_i.write;
    assign bus_take = bus_req & ~ack_q;
    assign wr_take = avmm_req_i.write & ack_q;
    assign avmm_rsp_o.waitrequest = bus_req & ~ack_q;
    assign avmm_rsp_o.readdata = rdata_q;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_take;
        end
    end

    // byte enables widened to a bit mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{avmm_req_i.byteenable[i]}};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // configuration register writes
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lut_mask_q <= `CELL_LUT_MASK_RST;
            cfg_q <= `CELL_CFG_RST;
            out_sel_q <= `CELL_OUT_SEL_RST;
        end else if (wr_take) begin
            case (avmm_req_i.address)
                `CELL_LUT_MASK_OFS: begin
                    lut_mask_q <= (lut_mask_q & ~wmask[15:0])
                                  | (avmm_req_i.writedata[15:0] & wmask[15:0]);
                end
                `CELL_CFG_OFS: begin
                    cfg_q <= (cfg_q & ~wmask[`CELL_CFG_WIDTH-1:0])
                             | (avmm_req_i.writedata[`CELL_CFG_WIDTH-1:0]
                                & wmask[`CELL_CFG_WIDTH-1:0]);
                end
                `CELL_OUT_SEL_OFS: begin
                    if (avmm_req_i.byteenable[0]) begin
                        out_sel_q <= avmm_req_i.writedata[`CELL_OUT_SEL_WIDTH-1:0];
                    end
                end
                default: begin
                    lut_mask_q <= lut_mask_q;
                end
            endcase
        end
    end

    // control register: clock strobe self-clears, clear and enable are levels
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_clk_q <= 1'b0;
            sw_clr_q <= 1'b0;
            sw_ce_q <= `CELL_CTRL_SW_CE_RST;
        end else begin
            sw_clk_q <= 1'b0;
            if (wr_take && avmm_req_i.address == `CELL_CTRL_OFS
                && avmm_req_i.byteenable[0]) begin
                sw_clk_q <= avmm_req_i.writedata[`CELL_CTRL_SW_CLK_BIT];
                sw_clr_q <= avmm_req_i.writedata[`CELL_CTRL_SW_CLR_BIT];
                sw_ce_q <= avmm_req_i.writedata[`CELL_CTRL_SW_CE_BIT];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read data, captured in the wait cycle, unmapped reads zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (avmm_req_i.address)
            `CELL_LUT_MASK_OFS: rdata_d[15:0] = lut_mask_q;
            `CELL_CFG_OFS: rdata_d[`CELL_CFG_WIDTH-1:0] = cfg_q;
            `CELL_OUT_SEL_OFS: rdata_d[`CELL_OUT_SEL_WIDTH-1:0] = out_sel_q;
            `CELL_CTRL_OFS: begin
                rdata_d[`CELL_CTRL_SW_CLR_BIT] = sw_clr_q;
                rdata_d[`CELL_CTRL_SW_CE_BIT] = sw_ce_q;
            end
            `CELL_STATUS_OFS: begin
                rdata_d[`CELL_STAT_Q_BIT] = reg_q;
                rdata_d[`CELL_STAT_LUT_BIT] = lut_result;
                rdata_d[`CELL_STAT_OUT_LSB +: 3] = route;
                rdata_d[`CELL_STAT_CARRY_BIT] = carry_bit;
                rdata_d[`CELL_STAT_CLR_BIT] = reg_clr | dev_clear_s;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_take && avmm_req_i.read) begin
            rdata_q <= rdata_d;
        end
    end

endmodule // logic_cell_top

// *** hdl/logic_cell_regs.svh ***
/*
 * Register offsets, field positions and reset values of the logic cell
 * configuration block.
 * Assumes byte addresses on a 32-bit Avalon-MM slave port.
 */
`ifndef LOGIC_CELL_REGS_SVH
`define LOGIC_CELL_REGS_SVH

// register byte offsets
`define CELL_LUT_MASK_OFS 5'h00
`define CELL_CFG_OFS 5'h04
`define CELL_OUT_SEL_OFS 5'h08
`define CELL_CTRL_OFS 5'h0C
`define CELL_STATUS_OFS 5'h10

// configuration register fields
`define CELL_CFG_FF_TYPE_LSB 0
`define CELL_CFG_CLK_SRC_LSB 2
`define CELL_CFG_CLR_SRC_LSB 4
`define CELL_CFG_CE_SRC_BIT 6
`define CELL_CFG_IN3_CARRY_BIT 7
`define CELL_CFG_ARITH_BIT 8
`define CELL_CFG_FEEDBACK_BIT 9
`define CELL_CFG_PACK_BIT 10
`define CELL_CFG_CHAIN_BIT 11
`define CELL_CFG_WIDTH 12

// output select register fields, 1 picks the register
`define CELL_OUT_SEL_WIDTH 3

// control register fields
`define CELL_CTRL_SW_CLK_BIT 0
`define CELL_CTRL_SW_CLR_BIT 1
`define CELL_CTRL_SW_CE_BIT 2

// status register fields
`define CELL_STAT_Q_BIT 0
`define CELL_STAT_LUT_BIT 1
`define CELL_STAT_OUT_LSB 2
`define CELL_STAT_CARRY_BIT 5
`define CELL_STAT_CLR_BIT 6

// reset values
`define CELL_LUT_MASK_RST 16'h0000
`define CELL_CFG_RST 12'h000
`define CELL_OUT_SEL_RST 3'h0
`define CELL_CTRL_SW_CE_RST 1'b1

// synchroniser depth for pin sources
`define CELL_SYNC_STAGES 2
`define CELL_PIN_COUNT 5

`endif

// *** hdl/cell_pkg.sv ***
/*
 * Types shared by the logic cell and its storage element.
 * Assumes the register header supplies all offsets and reset values.
 */
package cell_pkg;

    // storage element behaviour
    typedef enum logic [1:0] {
        FF_D,
        FF_T,
        FF_JK,
        FF_SR
    } ff_type_t;

    // sources of the register clock and clear
    typedef enum logic [1:0] {
        SRC_GLOBAL,
        SRC_PIN,
        SRC_LOGIC,
        SRC_NONE
    } ctl_src_t;

    // avalon-mm request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_t;

    // avalon-mm answer to the master
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } avmm_rsp_t;

    // three routing outputs of the cell
    typedef struct packed {
        logic local_out;
        logic direct_link;
        logic row_col;
    } route_out_t;

endpackage

// *** hdl/cell_storage.sv ***
/*
 * Programmable storage element of the logic cell: D, T, JK or SR behaviour.
 * Assumes tick_i marks the register's clock event, one cycle of clock_i wide.
 */
`timescale 1ns/1ps

module cell_storage (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic ce_i,
    input wire logic clr_i,
    input wire logic dev_clr_i,
    input wire logic sclr_i,
    input wire logic sload_i,
    input wire logic sload_data_i,
    input wire logic d_i,
    input wire logic aux_i,
    input wire cell_pkg::ff_type_t ff_type_i,
    output logic q_o
);
    import cell_pkg::*;

    logic q_q;
    logic q_d;

    //////////////////////////////////////////////////////////////////////////
    // next state for each flip-flop type
    always_comb begin
        q_d = q_q;
        case (ff_type_i)
            FF_D: q_d = d_i;
            FF_T: q_d = q_q ^ d_i;
            FF_JK: q_d = (d_i & ~q_q) | (~aux_i & q_q);
            FF_SR: q_d = (d_i & ~aux_i) ? 1'b1 : ((aux_i & ~d_i) ? 1'b0 : q_q);
            default: q_d = q_q;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // state update: device clear first, then clear, then clocked paths
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_q <= 1'b0;
        end else if (dev_clr_i) begin
            q_q <= 1'b0;
        end else if (clr_i) begin
            q_q <= 1'b0;
        end else if (tick_i && ce_i) begin
            if (sclr_i) begin
                q_q <= 1'b0;
            end else if (sload_i) begin
                q_q <= sload_data_i;
            end else begin
                q_q <= q_d;
            end
        end
    end

    // clear masks the output at once, no edge needed
    assign q_o = q_q & ~clr_i & ~dev_clr_i;

endmodule // cell_storage

// *** bench/logic_cell_monitor.sv ***
/*
 * Port checker for the logic cell: bus handshake, read data, device clear, carry.
 * Assumes a bind onto logic_cell_top, one clock domain, reset active low.
 */
`timescale 1ns/1ps

module logic_cell_monitor
    import cell_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire cell_pkg::avmm_req_t avmm_req_i,
    input wire cell_pkg::avmm_rsp_t avmm_rsp_o,
    input wire logic [3:0] data_i,
    input wire logic carry_i,
    input wire logic dev_clear_n_i,
    input wire logic carry_o,
    input wire logic chain_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // any request pending on the bus
    logic req;
    assign req = avmm_req_i.read | avmm_req_i.write;

    ////////////////////////////////////////////////////////////////////////////////////////
    // transfer completes at this edge
    sequence s_bus_done;
        req && !avmm_rsp_o.waitrequest;
    endsequence
    // device clear seen low through the synchroniser
    sequence s_dev_clr_held;
        (!dev_clear_n_i) [*3];
    endsequence

    property p_wait_bound;
        req |-> ##[0:1] !avmm_rsp_o.waitrequest;
    endproperty
    property p_wait_idle;
        !req |-> !avmm_rsp_o.waitrequest;
    endproperty
    property p_wait_first;
        s_bus_done |-> $past(avmm_rsp_o.waitrequest);
    endproperty
    property p_back_to_back;
        s_bus_done |=> (!req || avmm_rsp_o.waitrequest);
    endproperty
    property p_rdata_hold;
        !(avmm_req_i.read && avmm_rsp_o.waitrequest) |=> $stable(avmm_rsp_o.readdata);
    endproperty
    property p_unmapped;
        (s_bus_done and (avmm_req_i.read && avmm_req_i.address >= 5'h14))
            |-> avmm_rsp_o.readdata == 32'h0000_0000;
    endproperty
    property p_dev_clr;
        s_dev_clr_held |-> !chain_o;
    endproperty
    property p_carry_maj;
        carry_o |-> ((data_i[0] & data_i[1]) | (data_i[0] & carry_i) | (data_i[1] & carry_i));
    endproperty

    a_wait_bound: assert property (p_wait_bound) // bus answer within one cycle
        else $error("bus answer late");
    a_wait_idle: assert property (p_wait_idle) // no wait without request
        else $error("wait without request");
    a_wait_first: assert property (p_wait_first) // one wait cycle first
        else $error("bus answered with no wait cycle");
    a_back_to_back: assert property (p_back_to_back) // next request waits again
        else $error("back to back request not held");
    a_rdata_hold: assert property (p_rdata_hold) // read data stands
        else $error("read data moved without a read");
    a_unmapped: assert property (p_unmapped) // unmapped read gives zero
        else $error("unmapped read not zero");
    a_dev_clr: assert property (p_dev_clr)
        else $error("chain output high under device clear");
    a_carry_maj: assert property (p_carry_maj)
        else $error("carry out without two high adder inputs");
endmodule // logic_cell_monitor

// *** bench/neighbour_cells.sv ***
/*
 * Neighbour registers of the same cluster: one feeds the cell's chain input,
 * one takes the cell's chain output. Assumes the cell's clock and reset.
 */
`timescale 1ns/1ps

module neighbour_cells (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic up_d_i,
    input wire logic from_cell_i,
    output logic to_cell_o,
    output logic down_q_o
);
    // upstream register drives the chain input
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            to_cell_o <= 1'b0;
        end else begin
            to_cell_o <= up_d_i;
        end
    end

    // downstream register shifts the chain output on
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            down_q_o <= 1'b0;
        end else begin
            down_q_o <= from_cell_i;
        end
    end
endmodule // neighbour_cells

// *** bench/test_lut4_logic_cell.sv ***
/*
 * Self-checking bench for the logic cell: table rows, then register modes.
 * Assumes the monitor and neighbour model are compiled before this file.
 */
`timescale 1ns/1ps
`include "logic_cell_regs.svh"

module test_lut4_logic_cell;
    import cell_pkg::*;
    typedef struct packed {logic [15:0] mask; logic [3:0] data; logic exp;} row_t;
    localparam logic [31:0] CFG_D = 32'h0000_0070; // d type, global clock, no clear
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    avmm_req_t req = '0;
    avmm_rsp_t rsp;
    route_out_t route;
    logic [3:0] data = 4'h0;
    logic carry = 1'b0, sclr = 1'b0, sload = 1'b0, dev_n = 1'b1, up_d = 1'b0;
    logic [3:0] pin = 4'h0;
    logic chain_in, carry_o, chain_o, down_q, q0;
    int failures = 0;
    int compares = 0;
    row_t rows [6] = '{'{16'h8000, 4'hf, 1'b1}, '{16'h8000, 4'he, 1'b0},
        '{16'h6996, 4'h7, 1'b1}, '{16'h6996, 4'h3, 1'b0},
        '{16'h0001, 4'h0, 1'b1}, '{16'hfffe, 4'h0, 1'b0}};

    logic_cell_top logic_cell_top_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .avmm_req_i(req), .avmm_rsp_o(rsp),
        .data_i(data), .carry_i(carry), .chain_i(chain_in), .sync_clear_i(sclr),
        .sync_load_i(sload), .clear_global_i(pin[0]), .clock_pin_i(pin[1]), .clear_pin_i(pin[2]),
        .enable_pin_i(pin[3]), .dev_clear_n_i(dev_n), .route_o(route), .carry_o(carry_o),
        .chain_o(chain_o)
    );
    neighbour_cells neighbour_cells_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .up_d_i(up_d), .from_cell_i(chain_o),
        .to_cell_o(chain_in), .down_q_o(down_q)
    );

    always #5 clock_i = ~clock_i;

    ////////////////////////////////////////////////////////////////////////////////////////
    // one bus transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clock_i);
        req.read <= !w;
        req.write <= w;
        req.address <= a;
        req.writedata <= d;
        req.byteenable <= 4'hf;
        do begin
            @(posedge clock_i);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 50);
        if (n >= 50) failures++;
        r = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic ck1(input logic g, input logic e);
        check({31'h0, g}, {31'h0, e});
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        check(x, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog well beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge clock_i);
        failures++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rchk(`CELL_LUT_MASK_OFS, 32'h0000_0000);
        rchk(`CELL_CFG_OFS, 32'h0000_0000);
        rchk(`CELL_OUT_SEL_OFS, 32'h0000_0000);
        rchk(`CELL_CTRL_OFS, 32'h0000_0004);
        rchk(`CELL_STATUS_OFS, 32'h0000_0000);
        rchk(5'h14, 32'h0000_0000);
        $display("test reset values done");
        wr(`CELL_CFG_OFS, CFG_D);
        for (int i = 0; i < 6; i++) begin
            wr(`CELL_LUT_MASK_OFS, {16'h0000, rows[i].mask});
            @(posedge clock_i);
            data <= rows[i].data;
            settle(2);
            check({29'h0, route}, {29'h0, {3{rows[i].exp}}});
            ck1(chain_o, rows[i].exp);
        end
        $display("test table rows done");
        // local output from register, table changes under it
        wr(`CELL_OUT_SEL_OFS, 32'h0000_0004);
        @(posedge clock_i);
        data <= 4'h1;
        #1;
        check({29'h0, route}, 32'h0000_0003);
        wr(`CELL_LUT_MASK_OFS, 32'h0000_0001);
        wr(`CELL_CFG_OFS, 32'h0000_0470);
        wr(`CELL_OUT_SEL_OFS, 32'h0000_0002);
        @(posedge clock_i);
        data <= 4'h8;
        settle(2);
        check({29'h0, route}, 32'h0000_0002);
        @(posedge clock_i);
        data <= 4'h0;
        settle(2);
        check({29'h0, route}, 32'h0000_0005);
        wr(`CELL_OUT_SEL_OFS, 32'h0000_0000);
        $display("test output select done");
        wr(`CELL_LUT_MASK_OFS, 32'h0000_ffff);
        @(posedge clock_i);
        data <= 4'h2;
        for (int t = 0; t < 4; t++) begin
            wr(`CELL_CFG_OFS, CFG_D | 32'(t));
            settle(2);
            q0 = chain_o;
            settle(1);
            ck1(chain_o, (t == 0) ? 1'b1 : (t == 3) ? q0 : ~q0);
        end
        $display("test flip-flop types done");
        wr(`CELL_CFG_OFS, 32'h0000_0060);
        settle(2);
        ck1(chain_o, 1'b1);
        wr(`CELL_CTRL_OFS, 32'h0000_0000);
        wr(`CELL_LUT_MASK_OFS, 32'h0000_0000);
        settle(3);
        ck1(chain_o, 1'b1);
        wr(`CELL_CTRL_OFS, 32'h0000_0004);
        settle(2);
        ck1(chain_o, 1'b0);
        wr(`CELL_LUT_MASK_OFS, 32'h0000_ffff);
        settle(2);
        wr(`CELL_CTRL_OFS, 32'h0000_0006);
        #1;
        ck1(chain_o, 1'b0);
        wr(`CELL_CTRL_OFS, 32'h0000_0004);
        @(posedge clock_i);
        sclr <= 1'b1;
        settle(2);
        ck1(chain_o, 1'b0);
        @(posedge clock_i);
        sclr <= 1'b0;
        sload <= 1'b1;
        data <= 4'h8; // load value 0, table 1, packing value 1
        settle(2);
        ck1(chain_o, 1'b0);
        wr(`CELL_CFG_OFS, 32'h0000_0470);
        settle(2);
        ck1(chain_o, 1'b1);
        @(posedge clock_i);
        sload <= 1'b0;
        $display("test register controls done");
        wr(`CELL_CFG_OFS, 32'h0000_0270);
        wr(`CELL_LUT_MASK_OFS, 32'h0000_0f0f);
        settle(1);
        q0 = chain_o;
        settle(1);
        ck1(chain_o, ~q0);
        wr(`CELL_CFG_OFS, 32'h0000_00f0);
        wr(`CELL_LUT_MASK_OFS, 32'h0000_ff00);
        for (int i = 0; i < 2; i++) begin
            @(posedge clock_i);
            carry <= i[0];
            data <= {~i[0], 3'b000};
            settle(1);
            ck1(route.row_col, i[0]);
        end
        wr(`CELL_CFG_OFS, 32'h0000_0170);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock_i);
            data <= {2'b00, i[1:0]};
            carry <= i[2];
            settle(1);
            ck1(carry_o, (i[0] & i[1]) | (i[0] & i[2]) | (i[1] & i[2]));
            ck1(route.row_col, ^i[2:0]);
        end
        $display("test modes done");
        wr(`CELL_CFG_OFS, 32'h0000_0870);
        for (int i = 0; i < 2; i++) begin
            @(posedge clock_i);
            up_d <= i[0];
            settle(3);
            ck1(down_q, i[0]);
        end
        @(posedge clock_i);
        dev_n <= 1'b0;
        settle(3);
        ck1(chain_o, 1'b0);
        @(posedge clock_i);
        dev_n <= 1'b1;
        $display("test chain and device clear done");
        // pin sources
        @(posedge clock_i);
        pin <= 4'h8;
        data <= 4'h8;
        up_d <= 1'b0;
        wr(`CELL_CFG_OFS, 32'h0000_0014);
        settle(4);
        ck1(chain_o, 1'b0);
        @(posedge clock_i);
        pin <= 4'ha;
        settle(4);
        ck1(chain_o, 1'b1);
        @(posedge clock_i);
        pin <= 4'he;
        settle(3);
        ck1(chain_o, 1'b0);
        $display("test pin sources done");
        close_out();
    end
endmodule // test_lut4_logic_cell

bind logic_cell_top logic_cell_monitor logic_cell_monitor_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .avmm_req_i(avmm_req_i), .avmm_rsp_o(avmm_rsp_o),
    .data_i(data_i), .carry_i(carry_i), .dev_clear_n_i(dev_clear_n_i), .carry_o(carry_o),
    .chain_o(chain_o)
);
